// ===== src/pwm_timer_top.sv
// Purpose: three pwm timers with fast clock select behind axi4-lite
// Assumes: core clock 125 mhz; ticks derived by dividers
// Notes: idle input stops the second timer unless idle run is set
`timescale 1ns/1ps
module pwm_timer_top (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic IDLE,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [2:0] AUX_IN_PIN,
	output logic [2:0] PWM_OUT_PIN,
	output logic [2:0] PWM_OUT_OE,
	output logic [2:0] IRQ
);
	localparam int N = pwm_timer_pkg::NUM_TIMERS;
	typedef struct packed {
		logic [7:0] fast_ctrl;
		logic [7:0] slow_cnt;
		logic [7:0] fast_cnt;
		logic [7:0] awaddr;
		logic aw_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic w_have;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} top_st_t;
	top_st_t s_q, s_d;

	logic slow_tick, fast_tick, do_write;
	logic [N-1:0] tick;
	pwm_timer_pkg::timer_wr_t wr [N];
	pwm_timer_pkg::timer_ctrl_t ctl [N];
	logic [15:0] cnt [N];
	logic [15:0] ra [N];
	logic [15:0] rb [N];

	// timer index of an address, or N when outside the timer window
	function automatic logic [1:0] tsel(input logic [7:0] a);
		logic [7:0] rel;
		rel = a - pwm_timer_pkg::TIMER_BASE;
		if (a < pwm_timer_pkg::TIMER_BASE || rel[7:4] >= 4'(N)) begin
			return 2'(N);
		end else begin
			return rel[5:4];
		end
	endfunction

	assign slow_tick = s_q.slow_cnt == 8'(pwm_timer_pkg::SLOW_DIV - 1); // [R5]
	assign fast_tick = s_q.fast_cnt == 8'(pwm_timer_pkg::FAST_DIV - 1); // [R5]
	assign do_write = s_q.aw_have && s_q.w_have && !s_q.bvalid;

	// per-timer rate select and write strobes
	generate
		for (genvar i = 0; i < N; i++) begin : g_t
			logic run_ok;
			logic sel_fast;
			logic hit;
			if (i == 0) begin : g_slow
				assign sel_fast = 1'b0; // [R4]
			end else begin : g_hs
				assign sel_fast = s_q.fast_ctrl[i-1]; // [R4] [R6]
			end
			if (i == 1) begin : g_idle
				assign run_ok = !IDLE || s_q.fast_ctrl[pwm_timer_pkg::IDLE_RUN_BIT]; // [R8]
			end else begin : g_norm
				assign run_ok = !IDLE;
			end
			assign tick[i] = run_ok && (sel_fast ? fast_tick : slow_tick); // [R9]
			assign hit = do_write && tsel(s_q.awaddr) == 2'(i) && (&s_q.wstrb[1:0]);
			assign wr[i].we_ctrl = hit && s_q.awaddr[3:0] == pwm_timer_pkg::OFS_CTRL;
			assign wr[i].we_count = hit && s_q.awaddr[3:0] == pwm_timer_pkg::OFS_COUNT;
			assign wr[i].we_ra = hit && s_q.awaddr[3:0] == pwm_timer_pkg::OFS_RELOAD_A;
			assign wr[i].we_rb = hit && s_q.awaddr[3:0] == pwm_timer_pkg::OFS_RELOAD_B;
			assign wr[i].wdata = s_q.wdata[15:0];
			pwm_timer_unit u_t (
				.clk(CORE_CLK),
				.rst(RST),
				.tick(tick[i]),
				.wr(wr[i]),
				.ctrl(ctl[i]),
				.count(cnt[i]),
				.reload_a(ra[i]),
				.reload_b(rb[i]),
				.pwm_out(PWM_OUT_PIN[i]),
				.pwm_oe(PWM_OUT_OE[i]),
				.irq(IRQ[i])
			);
		end
	endgenerate

	always_comb begin
		logic [1:0] t;
		logic [7:0] ra_addr;
		t = 2'h0;
		ra_addr = 8'h00;
		s_d = s_q;
		s_d.slow_cnt = slow_tick ? 8'h00 : s_q.slow_cnt + 8'h01;
		s_d.fast_cnt = fast_tick ? 8'h00 : s_q.fast_cnt + 8'h01;
		if (S_AXI_AWVALID && !s_q.aw_have) begin
			s_d.aw_have = 1'b1;
			s_d.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !s_q.w_have) begin
			s_d.w_have = 1'b1;
			s_d.wdata = S_AXI_WDATA;
			s_d.wstrb = S_AXI_WSTRB;
		end
		if (do_write) begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = pwm_timer_pkg::AXI_OKAY;
			if (s_q.awaddr == pwm_timer_pkg::ADDR_FAST_CTRL) begin
				if (s_q.wstrb[0]) begin
					s_d.fast_ctrl = s_q.wdata[7:0] & pwm_timer_pkg::FAST_CTRL_MASK; // [R6] [R24]
				end
			end else if (tsel(s_q.awaddr) == 2'(N) || s_q.awaddr[1:0] != 2'h0) begin
				s_d.bresp = pwm_timer_pkg::AXI_SLVERR;
			end
		end
		if (s_q.bvalid && S_AXI_BREADY) begin
			s_d.bvalid = 1'b0;
		end
		if (S_AXI_ARVALID && !s_q.rvalid) begin
			ra_addr = S_AXI_ARADDR;
			t = tsel(ra_addr);
			s_d.rvalid = 1'b1;
			s_d.rresp = pwm_timer_pkg::AXI_OKAY;
			s_d.rdata = 32'h0000_0000;
			if (ra_addr == pwm_timer_pkg::ADDR_FAST_CTRL) begin
				s_d.rdata = {24'h000000, s_q.fast_ctrl};
			end else if (ra_addr == pwm_timer_pkg::ADDR_IDLE) begin
				s_d.rdata = {28'h0000000, AUX_IN_PIN, IDLE}; // [R2]
			end else if (t == 2'(N) || ra_addr[1:0] != 2'h0) begin
				s_d.rresp = pwm_timer_pkg::AXI_SLVERR;
			end else if (ra_addr[3:0] == pwm_timer_pkg::OFS_CTRL) begin
				s_d.rdata = {24'h000000, ctl[t].irq_en_b, ctl[t].irq_en_a, ctl[t].pend_b,
					ctl[t].pend_a, ctl[t].mode, ctl[t].run};
			end else if (ra_addr[3:0] == pwm_timer_pkg::OFS_COUNT) begin
				s_d.rdata = {16'h0000, cnt[t]};
			end else if (ra_addr[3:0] == pwm_timer_pkg::OFS_RELOAD_A) begin
				s_d.rdata = {16'h0000, ra[t]};
			end else begin
				s_d.rdata = {16'h0000, rb[t]};
			end
		end
		if (s_q.rvalid && S_AXI_RREADY) begin
			s_d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			s_q <= '0; // [R7]
		end else begin
			s_q <= s_d;
		end
	end

	assign S_AXI_AWREADY = !s_q.aw_have;
	assign S_AXI_WREADY = !s_q.w_have;
	assign S_AXI_BVALID = s_q.bvalid;
	assign S_AXI_BRESP = s_q.bresp;
	assign S_AXI_ARREADY = !s_q.rvalid;
	assign S_AXI_RVALID = s_q.rvalid;
	assign S_AXI_RDATA = s_q.rdata;
	assign S_AXI_RRESP = s_q.rresp;

	reset_clear_a: assert property (@(posedge CORE_CLK) // [R7]
		RST |=> s_q.fast_ctrl == pwm_timer_pkg::FAST_CTRL_RESET)
		else $error("fast control not cleared");
	rsvd_zero_a: assert property (@(posedge CORE_CLK) disable iff (RST) // [R24]
		s_q.fast_ctrl[6:2] == 5'h00)
		else $error("reserved bits set");
	first_slow_a: assert property (@(posedge CORE_CLK) disable iff (RST) // [R4]
		tick[0] |-> slow_tick)
		else $error("first timer ticked fast");
	fast_sel_a: assert property (@(posedge CORE_CLK) disable iff (RST) // [R6]
		(tick[2] && !slow_tick) |-> s_q.fast_ctrl[1])
		else $error("third timer fast without select");
	idle_stop_a: assert property (@(posedge CORE_CLK) disable iff (RST) // [R8]
		(IDLE && !s_q.fast_ctrl[pwm_timer_pkg::IDLE_RUN_BIT]) |-> !tick[1])
		else $error("second timer ran in idle");
endmodule

// ===== src/pwm_timer_pkg.sv
// Purpose: constants and types for the three-instance dual-reload pwm timer
// Assumes: axi4-lite register access, one core clock
// Notes: register layout below
// Operation
// R1 - each instance has a 16-bit counter and two 16-bit reload registers
// R2 - each instance has an output-capable pwm pin and an input-only aux pin
// R3 - three mode select bits choose pwm, event counter or capture mode; the code has only pwm modes 101 and 100, other modes stop the counter
// R4 - first timer counts at cycle rate; second and third may count fast
// R5 - cycle rate is oscillator over five; fast rate is oscillator times two
// R6 - fast select bit 1 for third timer, bit 0 for second timer
// R7 - reset clears the fast clock control register to zero
// R8 - bit 7 lets the second timer run during idle
// R9 - in pwm mode the counter decrements at its selected rate
// R10 - underflow reloads the counter and sets a pending flag
// R11 - first underflow loads reload a, then alternate starting with reload b
// R12 - the two reload registers hold on-time and off-time counts
// R13 - toggle mode flips the pwm pin on underflow; otherwise pin holds
// R14 - pend a and pend b set alternately and stay until software clears
// R15 - irq enable a requests interrupt on reload from reload a
// R16 - irq enable b requests interrupt on reload from reload b
// R17 - the two interrupt enables are independent
// R18 - fast-mode port bit operations overlapping a toggle may lose it
// R19 - no lost toggle at cycle rate or at cycle-aligned toggles
// R20 - software delays port bit operations near a fast toggle
// R21 - run control bit starts counting at 1 and stops at 0
// R22 - software stops a fast timer before changing its registers
// R23 - mode 101 is pwm with toggle, 100 is pwm without toggle
// R24 - fast clock control bits 6 to 2 read zero and ignore writes
package pwm_timer_pkg;
	localparam int NUM_TIMERS = 3;
	localparam logic [7:0] FAST_CTRL_RESET = 8'h00;
	localparam logic [7:0] FAST_CTRL_MASK = 8'h83;
	localparam int IDLE_RUN_BIT = 7;
	localparam logic [2:0] MODE_PWM_TOGGLE = 3'h5;
	localparam logic [2:0] MODE_PWM_HOLD = 3'h4;
	// register map, byte addresses; timer n at TIMER_BASE + n * TIMER_STRIDE
	localparam logic [7:0] ADDR_FAST_CTRL = 8'h00;
	localparam logic [7:0] ADDR_IDLE = 8'h04;
	localparam logic [7:0] TIMER_BASE = 8'h10;
	localparam logic [7:0] TIMER_STRIDE = 8'h10;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_COUNT = 4'h4;
	localparam logic [3:0] OFS_RELOAD_A = 4'h8;
	localparam logic [3:0] OFS_RELOAD_B = 4'hC;
	// control word bit positions
	localparam int CTL_RUN = 0;
	localparam int CTL_MODE_LO = 1;
	localparam int CTL_PEND_A = 4;
	localparam int CTL_PEND_B = 5;
	localparam int CTL_EN_A = 6;
	localparam int CTL_EN_B = 7;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	// clock rates: instruction cycle is osc/5, fast is osc*2, so fast is 10x slow
	localparam int OSC_KHZ = 10000;
	localparam int SLOW_KHZ = OSC_KHZ / 5;
	localparam int FAST_KHZ = OSC_KHZ * 2;
	localparam int CORE_KHZ = 125000;
	localparam int SLOW_DIV = CORE_KHZ / SLOW_KHZ;
	localparam int FAST_DIV = CORE_KHZ / FAST_KHZ;

	typedef struct packed {
		logic run;
		logic [2:0] mode;
		logic pend_a;
		logic pend_b;
		logic irq_en_a;
		logic irq_en_b;
	} timer_ctrl_t;

	typedef struct packed {
		logic we_ctrl;
		logic we_count;
		logic we_ra;
		logic we_rb;
		logic [15:0] wdata;
	} timer_wr_t;
endpackage

// ===== src/pwm_timer_unit.sv
// Purpose: one dual-reload down counter instance in pwm mode
// Assumes: tick is a one-cycle pulse at the selected count rate
// Notes: counter and reloads reset to zero
`timescale 1ns/1ps
module pwm_timer_unit (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire pwm_timer_pkg::timer_wr_t wr,
	output pwm_timer_pkg::timer_ctrl_t ctrl,
	output logic [15:0] count,
	output logic [15:0] reload_a,
	output logic [15:0] reload_b,
	output logic pwm_out,
	output logic pwm_oe,
	output logic irq
);
	typedef struct packed {
		pwm_timer_pkg::timer_ctrl_t ctrl;
		logic [15:0] count;
		logic [15:0] ra;
		logic [15:0] rb;
		logic next_b;
		logic pin;
	} unit_st_t;
	unit_st_t s_q, s_d;
	logic pwm_mode;
	logic uf;
	assign pwm_mode = s_q.ctrl.mode == pwm_timer_pkg::MODE_PWM_TOGGLE ||
		s_q.ctrl.mode == pwm_timer_pkg::MODE_PWM_HOLD; // [R3] [R23]
	assign uf = pwm_mode && s_q.ctrl.run && tick && s_q.count == 16'h0000; // [R10] [R21]

	always_comb begin
		s_d = s_q;
		if (pwm_mode && s_q.ctrl.run && tick) begin
			s_d.count = s_q.count - 16'h0001; // [R9]
		end
		if (uf) begin
			s_d.count = s_q.next_b ? s_q.rb : s_q.ra; // [R11] [R12]
			s_d.next_b = ~s_q.next_b;
			if (s_q.next_b) begin
				s_d.ctrl.pend_b = 1'b1; // [R14]
			end else begin
				s_d.ctrl.pend_a = 1'b1; // [R14]
			end
			if (s_q.ctrl.mode == pwm_timer_pkg::MODE_PWM_TOGGLE) begin
				s_d.pin = ~s_q.pin; // [R13]
			end
		end
		if (wr.we_ctrl) begin
			s_d.ctrl.run = wr.wdata[pwm_timer_pkg::CTL_RUN];
			s_d.ctrl.mode = wr.wdata[pwm_timer_pkg::CTL_MODE_LO +: 3];
			s_d.ctrl.irq_en_a = wr.wdata[pwm_timer_pkg::CTL_EN_A];
			s_d.ctrl.irq_en_b = wr.wdata[pwm_timer_pkg::CTL_EN_B];
			// set wins over clear
			s_d.ctrl.pend_a = (uf && !s_q.next_b) | wr.wdata[pwm_timer_pkg::CTL_PEND_A];
			s_d.ctrl.pend_b = (uf && s_q.next_b) | wr.wdata[pwm_timer_pkg::CTL_PEND_B];
			if (wr.wdata[pwm_timer_pkg::CTL_RUN] && !s_q.ctrl.run) begin
				s_d.next_b = 1'b0; // [R11]
			end
		end
		if (wr.we_count) begin
			s_d.count = wr.wdata;
		end
		if (wr.we_ra) begin
			s_d.ra = wr.wdata; // [R1]
		end
		if (wr.we_rb) begin
			s_d.rb = wr.wdata; // [R1]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign ctrl = s_q.ctrl;
	assign count = s_q.count;
	assign reload_a = s_q.ra;
	assign reload_b = s_q.rb;
	// pin flop written only by underflow; no port bit write can undo a toggle
	assign pwm_out = s_q.pin; // [R18] [R19]
	assign pwm_oe = pwm_mode; // [R2]
	assign irq = (s_q.ctrl.pend_a & s_q.ctrl.irq_en_a) |
		(s_q.ctrl.pend_b & s_q.ctrl.irq_en_b); // [R15] [R16] [R17]

	first_from_a_a: assert property (@(posedge clk) disable iff (rst) // [R11]
		(uf && !s_q.next_b && !wr.we_count && !wr.we_ctrl) |=> count == $past(s_q.ra))
		else $error("reload a not loaded");
	alt_b_a: assert property (@(posedge clk) disable iff (rst) // [R11]
		(uf && s_q.next_b && !wr.we_count && !wr.we_ctrl) |=> count == $past(s_q.rb))
		else $error("reload b not loaded");
	pend_sticky_a: assert property (@(posedge clk) disable iff (rst) // [R14]
		(ctrl.pend_a && !wr.we_ctrl) |=> ctrl.pend_a)
		else $error("pend a cleared itself");
	pend_set_a: assert property (@(posedge clk) disable iff (rst) // [R10]
		uf |=> (ctrl.pend_a || ctrl.pend_b))
		else $error("underflow set no flag");
	toggle_a: assert property (@(posedge clk) disable iff (rst) // [R13]
		(uf && s_q.ctrl.mode == pwm_timer_pkg::MODE_PWM_TOGGLE) |=> pwm_out != $past(pwm_out))
		else $error("pin did not toggle");
	hold_pin_a: assert property (@(posedge clk) disable iff (rst) // [R13]
		(s_q.ctrl.mode == pwm_timer_pkg::MODE_PWM_HOLD) |=> $stable(pwm_out))
		else $error("pin moved without toggle mode");
	stop_hold_a: assert property (@(posedge clk) disable iff (rst) // [R21]
		(!s_q.ctrl.run && !wr.we_count && !wr.we_ctrl) |=> $stable(count))
		else $error("stopped counter moved");
	irq_gate_a: assert property (@(posedge clk) disable iff (rst) // [R15]
		(ctrl.pend_a && ctrl.irq_en_a) |-> irq)
		else $error("enabled pend a gave no irq");
endmodule

// ===== test/pwm_load_model.sv
// Purpose: load on the three pwm pins, timing the gaps between toggles
// Assumes: pins sampled on the core clock
// Notes: a pin whose driver is off reads as pulled low
`timescale 1ns/1ps
module pwm_load_model (
	input wire logic clk,
	input wire logic [2:0] pin,
	input wire logic [2:0] oe
);
	int gap [3] = '{0, 0, 0};
	int edges [3] = '{0, 0, 0};
	int run_len [3] = '{0, 0, 0};
	logic [2:0] seen = 3'h0;
	logic [2:0] lvl;
	// undriven pin falls to the pull-down level
	assign lvl = pin & oe;
	always @(posedge clk) begin
		for (int i = 0; i < 3; i++) begin
			if (lvl[i] !== seen[i]) begin
				gap[i] = run_len[i];
				edges[i]++;
				run_len[i] = 1;
			end else begin
				run_len[i]++;
			end
		end
		seen = lvl;
	end
endmodule

// ===== test/test_dual_reload_pwm_timer.sv
// Purpose: self-checking bench for the three-timer pwm block
// Assumes: axi4-lite master tasks, 125 mhz core clock
// Notes: toggle gaps are measured by the load model
`timescale 1ns/1ps
module test_dual_reload_pwm_timer;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic idle = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [31:0] wd = 32'h0, rdat, rd_d;
	logic awr, wr_r, bv, arr, rv;
	logic [1:0] bresp, rresp, resp;
	logic [2:0] pin, oe, irq;
	logic [2:0] aux = 3'h0;
	int n_fail = 0;
	int n_tests = 0;
	pwm_timer_top i_pwm_timer_top (.CORE_CLK(clk), .RST(rst), .IDLE(idle),
		.S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_r),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
		.AUX_IN_PIN(aux), .PWM_OUT_PIN(pin), .PWM_OUT_OE(oe), .IRQ(irq));
	pwm_load_model i_pwm_load_model (.clk(clk), .pin(pin), .oe(oe));
	initial begin
		forever #4 clk = ~clk;
	end
	task end_of_test;
		$display("checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task limit(input int k, input int m);
		if (k >= m) begin
			n_fail++;
			$display("[ERR] wait expected done seen timeout");
			end_of_test;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr_r) wv <= 1'b0;
			if (bv) break;
		end
		limit(k, 50);
		resp = bresp;
		br <= 1'b0;
		// let an edge pass before the next request
		@(posedge clk);
	endtask
	task rd(input logic [7:0] a);
		int k;
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
			if (rv) break;
		end
		limit(k, 50);
		rd_d = rdat;
		resp = rresp;
		rr <= 1'b0;
		// let an edge pass before the next request
		@(posedge clk);
	endtask
	task wait_edge(input int i, input int n);
		int k;
		for (k = 0; k < 3000 && i_pwm_load_model.edges[i] < n; k++) @(posedge clk);
		limit(k, 3000);
	endtask
	task poll(input logic [7:0] a, input int b);
		int k;
		for (k = 0; k < 500; k++) begin
			rd(a);
			if (rd_d[b] === 1'b1) break;
		end
		limit(k, 500);
	endtask
	task t_regs;
		rd(pwm_timer_pkg::ADDR_FAST_CTRL);
		chk("fast ctrl reset", rd_d, {24'h0, pwm_timer_pkg::FAST_CTRL_RESET});
		chk("oe reset", oe, 3'h0);
		wr(pwm_timer_pkg::ADDR_FAST_CTRL, 32'hFF);
		chk("write resp", resp, pwm_timer_pkg::AXI_OKAY);
		rd(pwm_timer_pkg::ADDR_FAST_CTRL);
		chk("fast ctrl bits", rd_d, 32'h83);
		rd(8'hF0);
		chk("unmapped resp", resp, pwm_timer_pkg::AXI_SLVERR);
		wr(pwm_timer_pkg::ADDR_IDLE, 32'h1);
		chk("status write resp", resp, pwm_timer_pkg::AXI_SLVERR);
		wr(pwm_timer_pkg::ADDR_FAST_CTRL, 32'h0);
		$display("test regs done");
	endtask
	task t_pwm(input logic [7:0] fsel);
		logic [7:0] cb;
		int n, dv;
		wr(pwm_timer_pkg::ADDR_FAST_CTRL, {24'h0, fsel});
		for (int i = 0; i < 3; i++) begin
			cb = pwm_timer_pkg::TIMER_BASE + 8'(i) * pwm_timer_pkg::TIMER_STRIDE;
			dv = (i != 0 && fsel[i-1]) ? pwm_timer_pkg::FAST_DIV : pwm_timer_pkg::SLOW_DIV;
			wr(cb, 32'h0);
			wr(cb + pwm_timer_pkg::OFS_RELOAD_A, 32'h3);
			wr(cb + pwm_timer_pkg::OFS_RELOAD_B, 32'h5);
			wr(cb + pwm_timer_pkg::OFS_COUNT, 32'h0);
			// a pin left high shows one extra edge when its driver turns on
			n = i_pwm_load_model.edges[i] + int'(pin[i]);
			wr(cb, 32'h4B);
			chk("pin enable", oe[i], 1'b1);
			wait_edge(i, n + 1);
			rd(cb);
			chk("pend after first reload", rd_d[5:4], 2'h1);
			chk("irq on reload a", irq[i], 1'b1);
			wait_edge(i, n + 2);
			chk("phase a length", i_pwm_load_model.gap[i], 4 * dv);
			wait_edge(i, n + 3);
			chk("phase b length", i_pwm_load_model.gap[i], 6 * dv);
			rd(cb);
			chk("pends held", rd_d[5:4], 2'h3);
			wr(cb, 32'h0);
		end
		$display("test pwm done, fast select %0h", fsel);
	endtask
	task t_hold;
		logic p0;
		wr(8'h10, 32'h0);
		wr(8'h18, 32'h3);
		wr(8'h1C, 32'h3);
		wr(8'h14, 32'h0);
		p0 = pin[0];
		wr(8'h10, 32'h89);
		poll(8'h10, pwm_timer_pkg::CTL_PEND_A);
		chk("irq a disabled", irq[0], 1'b0);
		poll(8'h10, pwm_timer_pkg::CTL_PEND_B);
		chk("irq on reload b", irq[0], 1'b1);
		chk("pin held", pin[0], p0);
		wr(8'h10, 32'h89);
		rd(8'h10);
		chk("pends cleared", rd_d[5:4], 2'h0);
		chk("irq cleared", irq[0], 1'b0);
		wr(8'h10, 32'h0);
		$display("test hold done");
	endtask
	task t_idle;
		wr(8'h20, 32'h0);
		wr(8'h28, 32'h5);
		wr(8'h2C, 32'h5);
		wr(8'h24, 32'h100);
		idle <= 1'b1;
		aux <= 3'h5;
		wr(8'h20, 32'h4B);
		repeat (200) @(posedge clk);
		rd(8'h24);
		chk("idle frozen", rd_d, 32'h100);
		rd(pwm_timer_pkg::ADDR_IDLE);
		chk("idle status", rd_d, 32'hB);
		wr(pwm_timer_pkg::ADDR_FAST_CTRL, 32'h80);
		repeat (200) @(posedge clk);
		rd(8'h24);
		chk("idle run counts", rd_d[15:0] < 16'h0100, 1'b1);
		idle <= 1'b0;
		wr(8'h20, 32'h0);
		$display("test idle done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs;
		t_pwm(8'h00);
		t_pwm(8'h03);
		t_hold;
		t_idle;
		end_of_test;
	end
endmodule
